// *** hw/serial_diag_port.sv ***
/*
  single-pin transmit-only diagnostic port: key-protected control
  register, three 16-bit data registers, byte loader, fifo and frame
  serializer.
  assumes a simple register port (address, write strobe, read strobe)
  and a bit-rate tick from an external timer overflow.
*/
// Functional notes
// RULE1: first data register: byte one in low half, byte two high.
// RULE2: second data register: byte three low half, byte four high.
// RULE3: third data register: byte five low half, byte six high.
// RULE4: control write commits only between key 0x0007 and key 0x00b9.
// RULE5: software writes zeros to control bits 15 to 9.
// RULE6: control bits 8 to 5 read nonzero while sending, zero idle.
// RULE7: control bits 4 to 2 select one to six bytes.
// RULE8: software loads data registers after programming the count.
// RULE9: control bit 1 resets the port; control then reads zero.
// RULE10: control bit 0 enables the port.
// RULE11: software routes the shared pin to this function.
// RULE12: each byte goes out as start, eight data, parity, two stops.
// RULE13: each timer overflow tick times one bit.
// RULE14: sending waits for all needed data; control restores when done.
// RULE15: data goes lsb first with even parity.
`timescale 1ns/1ps
module serial_diag_port
  import serial_diag_pkg::*;
(
  input  wire logic                               clk_sys_in,
  input  wire logic                               rstn_in,
  input  wire logic [serial_diag_pkg::ADDR_W-1:0] bus_addr_in,
  input  wire logic [serial_diag_pkg::DATA_W-1:0] bus_wdata_in,
  input  wire logic                               bus_wr_in,
  input  wire logic                               bus_rd_in,
  output logic      [serial_diag_pkg::DATA_W-1:0] bus_rdata_out,
  input  wire logic                               baud_tick_in,
  output logic                                    serial_diag_port_out
);
  import serial_diag_pkg::*;

  // ----------
  // declarations
  // ----------
  key_state_t               key_state;
  tx_state_t                tx_state;
  logic [DATA_W-1:0]        held_ctrl;
  logic [CTRL_STORED_W-1:0] ctrl;
  logic [DATA_W-1:0]        data_reg [NUM_DATA_REGS];
  logic [NUM_DATA_REGS-1:0] reg_written;
  logic [2:0]               byte_idx;
  logic                     commit;
  logic                     soft_reset;
  logic                     wr_data_any;
  logic [NUM_DATA_REGS-1:0] wr_data_sel;
  logic                     start_tx;
  logic                     done_tx;
  logic                     fifo_empty;
  logic                     ser_busy;
  logic [2:0]               count_code;
  logic [DATA_W-1:0]        ctrl_view;

  byte_stream_if #(.W(BYTE_W)) load_bus ();
  byte_stream_if #(.W(BYTE_W)) ser_bus ();

  // ----------
  // helpers
  // ----------
  function automatic logic [2:0] last_index(input logic [2:0] code);
    last_index = (code > COUNT_MAX_CODE) ? COUNT_MAX_CODE : code;
  endfunction

  function automatic logic [NUM_DATA_REGS-1:0] regs_needed(
    input logic [2:0] code);
    case (last_index(code))
      3'h0, 3'h1: regs_needed = 3'h1;
      3'h2, 3'h3: regs_needed = 3'h3;
      default:    regs_needed = 3'h7;
    endcase
  endfunction

  function automatic logic [BYTE_W-1:0] pick_byte(input logic [2:0] idx,
    input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
    input logic [DATA_W-1:0] d2);
    case (idx)
      3'h0:    pick_byte = d0[BYTE_W-1:0];      // [RULE1]
      3'h1:    pick_byte = d0[DATA_W-1:BYTE_W]; // [RULE1]
      3'h2:    pick_byte = d1[BYTE_W-1:0];      // [RULE2]
      3'h3:    pick_byte = d1[DATA_W-1:BYTE_W]; // [RULE2]
      3'h4:    pick_byte = d2[BYTE_W-1:0];      // [RULE3]
      default: pick_byte = d2[DATA_W-1:BYTE_W]; // [RULE3]
    endcase
  endfunction

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_data_sel[0] = bus_wr_in && bus_addr_in == OFS_DATA_BYTES_1_2;
  assign wr_data_sel[1] = bus_wr_in && bus_addr_in == OFS_DATA_BYTES_3_4;
  assign wr_data_sel[2] = bus_wr_in && bus_addr_in == OFS_DATA_BYTES_5_6;
  assign wr_data_any    = |wr_data_sel;
  assign commit         = bus_wr_in && key_state == KEY_HELD &&
                          bus_addr_in == OFS_UNLOCK_KEY_SECOND &&
                          bus_wdata_in == KEY_SECOND_VALUE; // [RULE4]
  assign soft_reset     = commit && held_ctrl[CTRL_SRST_BIT];  // [RULE9]
  assign count_code     = ctrl[CTRL_COUNT_MSB:CTRL_COUNT_LSB];

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      key_state <= KEY_IDLE;
      held_ctrl <= CONTROL_RESET;
    end
    else if (bus_wr_in)
    begin
      case (key_state)
        KEY_ARMED:
        begin
          if (bus_addr_in == OFS_CONTROL)
          begin
            key_state <= KEY_HELD; // [RULE4]
            held_ctrl <= bus_wdata_in;
          end
          else if (bus_addr_in == OFS_UNLOCK_KEY_FIRST &&
                   bus_wdata_in == KEY_FIRST_VALUE)
          begin
            key_state <= KEY_ARMED;
          end
          else
          begin
            key_state <= KEY_IDLE;
          end
        end
        default:
        begin
          // any other write breaks the sequence, a fresh first key rearms
          if (bus_addr_in == OFS_UNLOCK_KEY_FIRST &&
              bus_wdata_in == KEY_FIRST_VALUE)
          begin
            key_state <= KEY_ARMED; // [RULE4]
          end
          else
          begin
            key_state <= KEY_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl <= CONTROL_RESET[CTRL_STORED_W-1:0];
    end
    else if (soft_reset)
    begin
      ctrl <= CONTROL_RESET[CTRL_STORED_W-1:0]; // [RULE9]
    end
    else if (commit)
    begin
      // reset bit is never stored, reserved bits are dropped
      ctrl <= held_ctrl[CTRL_STORED_W-1:0] &
              ~(CTRL_STORED_W'(1) << CTRL_SRST_BIT); // [RULE5] [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < NUM_DATA_REGS; i++)
      begin
        data_reg[i] <= DATA_RESET;
      end
    end
    else if (soft_reset)
    begin
      for (int i = 0; i < NUM_DATA_REGS; i++)
      begin
        data_reg[i] <= DATA_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_DATA_REGS; i++)
      begin
        if (wr_data_sel[i])
        begin
          data_reg[i] <= bus_wdata_in;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // data written flags, a write wins over the start-of-send clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_written <= '0;
    end
    else if (soft_reset)
    begin
      reg_written <= '0;
    end
    else
    begin
      reg_written <= (start_tx ? '0 : reg_written) | wr_data_sel; // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // transmit controller
  // ----------------------------------------------------------------
  assign start_tx = tx_state == TX_IDLE && ctrl[CTRL_ENABLE_BIT] &&
                    (reg_written & regs_needed(count_code)) ==
                    regs_needed(count_code) && !wr_data_any; // [RULE14]
  assign done_tx  = tx_state == TX_DRAIN && fifo_empty && !ser_busy;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tx_state <= TX_IDLE;
      byte_idx <= '0;
    end
    else if (soft_reset)
    begin
      tx_state <= TX_IDLE;
      byte_idx <= '0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          byte_idx <= '0;
          if (start_tx)
          begin
            tx_state <= TX_LOAD; // [RULE10] [RULE14]
          end
        end
        TX_LOAD:
        begin
          if (!ctrl[CTRL_ENABLE_BIT])
          begin
            tx_state <= TX_DRAIN; // [RULE10]
          end
          else if (load_bus.ready)
          begin
            if (byte_idx == last_index(count_code))
            begin
              tx_state <= TX_DRAIN; // [RULE7]
            end
            byte_idx <= byte_idx + 1'b1;
          end
        end
        TX_DRAIN:
        begin
          if (done_tx)
          begin
            tx_state <= TX_IDLE; // [RULE14]
          end
        end
        default:
        begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  assign load_bus.valid = tx_state == TX_LOAD && ctrl[CTRL_ENABLE_BIT];
  assign load_bus.data  = pick_byte(byte_idx, data_reg[0], data_reg[1],
                                    data_reg[2]);

  // ----------------------------------------------------------------
  // fifo and serializer
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .flush_in   (soft_reset),
    .fill       (load_bus),
    .drain      (ser_bus),
    .empty_out  (fifo_empty)
  );

  frame_serializer u_ser (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .flush_in     (soft_reset),
    .baud_tick_in (baud_tick_in),
    .bytes        (ser_bus),
    .line_out     (serial_diag_port_out),
    .busy_out     (ser_busy)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  assign ctrl_view = {{CTRL_RSVD_W{1'b0}}, tx_state, ctrl}; // [RULE6]

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bus_rdata_out <= '0;
    end
    else if (bus_rd_in)
    begin
      case (bus_addr_in)
        OFS_CONTROL:        bus_rdata_out <= ctrl_view;
        OFS_DATA_BYTES_1_2: bus_rdata_out <= data_reg[0];
        OFS_DATA_BYTES_3_4: bus_rdata_out <= data_reg[1];
        OFS_DATA_BYTES_5_6: bus_rdata_out <= data_reg[2];
        default:            bus_rdata_out <= '0;
      endcase
    end
  end
endmodule // serial_diag_port

// *** hw/serial_diag_pkg.sv ***
/*
  shared constants and types for the single-pin diagnostic transmitter:
  register byte addresses, unlock keys, control field positions, frame
  shape and controller states.
  assumes a 16-bit memory-mapped register port with byte addresses.
*/
package serial_diag_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 32;
  localparam int DATA_W        = 16;
  localparam int BYTE_W        = 8;
  localparam int NUM_DATA_REGS = 3;
  localparam int FIFO_DEPTH    = 8;
  localparam int FRAME_BITS    = 12;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_UNLOCK_KEY_FIRST  = 32'hffff0880;
  localparam logic [ADDR_W-1:0] OFS_CONTROL           = 32'hffff0884;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK_KEY_SECOND = 32'hffff0888;
  localparam logic [ADDR_W-1:0] OFS_DATA_BYTES_1_2    = 32'hffff088c;
  localparam logic [ADDR_W-1:0] OFS_DATA_BYTES_3_4    = 32'hffff0890;
  localparam logic [ADDR_W-1:0] OFS_DATA_BYTES_5_6    = 32'hffff0894;

  // ----------------------------------------------------------------
  // key values and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] KEY_FIRST_VALUE  = 16'h0007;
  localparam logic [DATA_W-1:0] KEY_SECOND_VALUE = 16'h00b9;
  localparam logic [DATA_W-1:0] CONTROL_RESET    = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET       = 16'h0000;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SRST_BIT   = 1;
  localparam int CTRL_COUNT_LSB  = 2;
  localparam int CTRL_COUNT_MSB  = 4;
  localparam int CTRL_STATE_LSB  = 5;
  localparam int CTRL_STATE_MSB  = 8;
  localparam int CTRL_STORED_W   = CTRL_COUNT_MSB + 1;
  localparam int CTRL_RSVD_W     = DATA_W - CTRL_STATE_MSB - 1;
  localparam logic [2:0] COUNT_MAX_CODE = 3'h5;

  // ----------------------------------------------------------------
  // frame shape
  // ----------------------------------------------------------------
  localparam logic       START_LEVEL = 1'b0;
  localparam logic [1:0] STOP_LEVELS = 2'h3;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    KEY_IDLE  = 2'b00,
    KEY_ARMED = 2'b01,
    KEY_HELD  = 2'b10
  } key_state_t;

  typedef enum logic [3:0]
  {
    TX_IDLE  = 4'b0000,
    TX_LOAD  = 4'b0001,
    TX_DRAIN = 4'b0010
  } tx_state_t;

endpackage

// *** hw/byte_stream_if.sv ***
/*
  valid/ready byte stream between the controller, the fifo and the
  frame serializer.
  assumes all parties share one clock.
*/
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport producer (output data, output valid, input ready);
  modport consumer (input data, input valid, output ready);
endinterface

// *** hw/byte_fifo.sv ***
/*
  flip-flop fifo with valid/ready on both sides and a synchronous flush.
  assumes depth is a power of two.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic          clk_sys_in,
  input  wire logic          rstn_in,
  input  wire logic          flush_in,
  byte_stream_if.consumer    fill,
  byte_stream_if.producer    drain,
  output logic               empty_out
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             push;
  logic             pop;

  // ----------
  // handshakes
  // ----------
  assign fill.ready  = (count != CNT_W'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rd_ptr];
  assign empty_out   = (count == '0);
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  // ----------
  // storage
  // ----------
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= fill.data;
    end
  end

  // ----------
  // pointers and level
  // ----------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// *** hw/frame_serializer.sv ***
/*
  turns bytes into 12-bit frames on one line, one bit per baud tick:
  start, eight data bits lsb first, even parity, two stop bits.
  assumes baud_tick_in is a one-cycle pulse per bit period.
*/
`timescale 1ns/1ps
module frame_serializer
  import serial_diag_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          rstn_in,
  input  wire logic          flush_in,
  input  wire logic          baud_tick_in,
  byte_stream_if.consumer    bytes,
  output logic               line_out,
  output logic               busy_out
);
  localparam int CNT_W = $clog2(FRAME_BITS + 1);

  logic [FRAME_BITS-1:0] shreg;
  logic [CNT_W-1:0]      bits_left;
  logic                  take;

  // accept a byte on a tick when idle or on the last stop bit
  assign bytes.ready = baud_tick_in & (bits_left <= CNT_W'(1));
  assign take        = bytes.ready & bytes.valid;
  assign line_out    = shreg[0];
  assign busy_out    = (bits_left != '0);

  // ----------
  // shift register
  // ----------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      shreg     <= '1;
      bits_left <= '0;
    end
    else if (flush_in)
    begin
      shreg     <= '1;
      bits_left <= '0;
    end
    else if (take)
    begin
      shreg     <= {STOP_LEVELS, ^bytes.data, bytes.data,
                    START_LEVEL}; // [RULE12] [RULE15]
      bits_left <= CNT_W'(FRAME_BITS);
    end
    else if (baud_tick_in && bits_left != '0)
    begin
      shreg     <= {1'b1, shreg[FRAME_BITS-1:1]}; // [RULE13]
      bits_left <= bits_left - 1'b1;
    end
  end
endmodule // frame_serializer

// *** dv/serial_diag_port_properties.sv ***
/*
  pin-level checker for serial_diag_port.
  assumes bind to the top module, one clock.
*/
`timescale 1ns/1ps
module serial_diag_port_checker
  import serial_diag_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              rstn_in,
  input wire logic [ADDR_W-1:0] bus_addr_in,
  input wire logic [DATA_W-1:0] bus_wdata_in,
  input wire logic              bus_wr_in,
  input wire logic              bus_rd_in,
  input wire logic [DATA_W-1:0] bus_rdata_out,
  input wire logic              baud_tick_in,
  input wire logic              serial_diag_port_out
);
  // ----------
  // helper models
  // ----------
  key_state_t  kst;
  logic [15:0] pend;
  logic [4:0]  ctl;
  logic [3:0]  n, wr_hist;
  logic [7:0]  dat;
  logic        t1, t2, act, commit;
  assign commit = bus_wr_in && kst == KEY_HELD
    && bus_addr_in == OFS_UNLOCK_KEY_SECOND
    && bus_wdata_in == KEY_SECOND_VALUE;
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      kst  <= KEY_IDLE;
      pend <= 16'h0000;
      ctl  <= 5'h00;
    end
    else if (bus_wr_in)
    begin
      if (bus_addr_in == OFS_UNLOCK_KEY_FIRST
          && bus_wdata_in == KEY_FIRST_VALUE)
        kst <= KEY_ARMED;
      else if (kst == KEY_ARMED && bus_addr_in == OFS_CONTROL)
      begin
        kst  <= KEY_HELD;
        pend <= bus_wdata_in;
      end
      else
      begin
        kst <= KEY_IDLE;
        if (commit)
          ctl <= pend[1] ? 5'h00 : pend[4:0];
      end
    end
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      {t1, t2, act, n, dat, wr_hist} <= '0;
    end
    else
    begin
      t1      <= baud_tick_in;
      t2      <= t1;
      wr_hist <= {wr_hist[2:0], bus_wr_in};
      if (commit && pend[1])
        act <= 1'b0;
      else if (t2 && !act)
      begin
        act <= !serial_diag_port_out && wr_hist == 4'h0;
        n   <= 4'h1;
      end
      else if (t2)
      begin
        if (n <= 4'h8)
          dat <= {serial_diag_port_out, dat[7:1]};
        n <= n + 4'h1;
        if (n == 4'hb)
          act <= 1'b0;
      end
    end
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_ctl_read;
    bus_rd_in && bus_addr_in == OFS_CONTROL && !commit;
  endsequence
  sequence s_bit;
    t2 && act;
  endsequence
  property p_ctl_enable;
    s_ctl_read |=> bus_rdata_out[0] == ctl[0];
  endproperty
  a_ctl_enable: assert property (p_ctl_enable)
    else $error("control enable readback wrong");
  property p_ctl_count;
    s_ctl_read |=> bus_rdata_out[4:2] == ctl[4:2];
  endproperty
  a_ctl_count: assert property (p_ctl_count)
    else $error("control count readback wrong");
  property p_ctl_srst;
    s_ctl_read |=> !bus_rdata_out[1];
  endproperty
  a_ctl_srst: assert property (p_ctl_srst)
    else $error("reset bit reads one");
  property p_ctl_rsvd;
    s_ctl_read |=> bus_rdata_out[15:9] == 7'h00;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd)
    else $error("reserved control bits nonzero");
  property p_state_busy;
    s_ctl_read ##0 act |=> bus_rdata_out[8:5] != 4'h0;
  endproperty
  a_state_busy: assert property (p_state_busy)
    else $error("state bits zero while sending");
  property p_stop;
    s_bit ##0 n >= 4'ha |-> serial_diag_port_out;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop bit low");
  property p_parity;
    s_bit ##0 n == 4'h9 |-> serial_diag_port_out == ^dat;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity bit wrong");
  property p_hold;
    !t1 && !t2 && wr_hist == 4'h0 |-> $stable(serial_diag_port_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("line moved without a tick");
endmodule // serial_diag_port_checker

bind serial_diag_port serial_diag_port_checker u_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
  .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
  .bus_rdata_out(bus_rdata_out), .baud_tick_in(baud_tick_in),
  .serial_diag_port_out(serial_diag_port_out));

// *** dv/diag_receiver_model.sv ***
/*
  receiver on the diagnostic pin: samples each bit two cycles
  after its tick and reports each 12-bit frame.
  assumes ticks at least three cycles apart.
*/
`timescale 1ns/1ps
module diag_receiver_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  input  wire logic       tick_in,
  input  wire logic       line_in,
  output logic      [7:0] rx_byte_out,
  output logic            rx_ok_out,
  output logic            rx_stb_out
);
  // ----------
  // frame capture
  // ----------
  logic [10:0] sh;
  logic [10:0] nv;
  logic [3:0]  n;
  logic        t1, t2;
  assign nv = {line_in, sh[10:1]};
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      {sh, n, t1, t2, rx_byte_out, rx_ok_out, rx_stb_out} <= '0;
    end
    else
    begin
      t1         <= tick_in;
      t2         <= t1;
      rx_stb_out <= 1'b0;
      if (t2 && n == 4'h0)
        n <= line_in ? 4'h0 : 4'h1;
      else if (t2)
      begin
        sh <= nv;
        n  <= (n == 4'hb) ? 4'h0 : n + 4'h1;
        if (n == 4'hb)
        begin
          rx_byte_out <= nv[7:0];
          rx_ok_out   <= nv[8] == ^nv[7:0] && nv[10:9] == 2'h3;
          rx_stb_out  <= 1'b1;
        end
      end
    end
endmodule // diag_receiver_model

// *** dv/tb_top.sv ***
/*
  self-checking bench for serial_diag_port.
  assumes the receiver model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  import serial_diag_pkg::*;
  logic              clk_sys_in, rstn_in, bus_wr_in, bus_rd_in;
  logic              baud_tick_in, line, rx_ok, rx_stb;
  logic [ADDR_W-1:0] bus_addr_in;
  logic [DATA_W-1:0] bus_wdata_in, bus_rdata_out, v;
  logic [DATA_W-1:0] d [3];
  logic [7:0]        rx_byte;
  logic [2:0]        tcnt;
  logic [8:0]        rxq [$];
  int                err_total, compares;

  serial_diag_port dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_rdata_out(bus_rdata_out), .baud_tick_in(baud_tick_in),
    .serial_diag_port_out(line));
  diag_receiver_model rx (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .tick_in(baud_tick_in), .line_in(line), .rx_byte_out(rx_byte),
    .rx_ok_out(rx_ok), .rx_stb_out(rx_stb));

  // ----------
  // clock, tick, capture, watchdog
  // ----------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in)
  begin
    tcnt         <= tcnt + 3'h1;
    baud_tick_in <= tcnt == 3'h7;
  end
  always @(posedge clk_sys_in)
    if (rx_stb)
      rxq.push_back({rx_ok, rx_byte});
  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end

  // ----------
  // tasks
  // ----------
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] w);
    bus_addr_in  = a;
    bus_wdata_in = w;
    bus_wr_in    = 1'b1;
    @(negedge clk_sys_in);
    bus_wr_in = 1'b0;
    @(negedge clk_sys_in);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] r);
    bus_addr_in = a;
    bus_rd_in   = 1'b1;
    @(negedge clk_sys_in);
    bus_rd_in = 1'b0;
    r         = bus_rdata_out;
    @(negedge clk_sys_in);
  endtask
  function automatic logic [ADDR_W-1:0] dreg(input int i);
    return OFS_DATA_BYTES_1_2 + ADDR_W'(4 * i);
  endfunction
  task automatic unlock(input logic [15:0] w);
    wr(OFS_UNLOCK_KEY_FIRST, KEY_FIRST_VALUE);
    wr(OFS_CONTROL, w);
    wr(OFS_UNLOCK_KEY_SECOND, KEY_SECOND_VALUE);
  endtask
  task automatic wait_ctl(input logic [15:0] e);
    int i;
    v = ~e;
    for (i = 0; i < 400 && v !== e; i++)
      rd(OFS_CONTROL, v);
    chk("control restored", e, v);
  endtask

  task automatic t_reset_values;
    for (int i = -3; i < 4; i++)
    begin
      rd(dreg(i), v);
      chk("reset read", 16'h0000, v);
    end
  endtask
  task automatic t_key_guard;
    wr(OFS_CONTROL, 16'h0011);
    rd(OFS_CONTROL, v);
    chk("unkeyed control", 16'h0000, v);
    wr(OFS_UNLOCK_KEY_FIRST, KEY_FIRST_VALUE);
    wr(OFS_CONTROL, 16'h0011);
    wr(OFS_UNLOCK_KEY_SECOND, 16'h00b8);
    rd(OFS_CONTROL, v);
    chk("bad key control", 16'h0000, v);
    unlock(16'h0014);
    rd(OFS_CONTROL, v);
    chk("keyed control", 16'h0014, v);
  endtask
  task automatic t_disabled;
    for (int i = 0; i < 3; i++)
      wr(dreg(i), d[i]);
    repeat (240) @(negedge clk_sys_in);
    chk("frames while off", 16'h0000, 16'(rxq.size()));
    for (int i = 0; i < 3; i++)
    begin
      rd(dreg(i), v);
      chk("data readback", d[i], v);
    end
  endtask
  task automatic t_soft_reset;
    unlock(16'h0015);
    repeat (40) @(negedge clk_sys_in);
    rd(OFS_CONTROL, v);
    chk("state busy", 16'h0001, 16'(v[8:5] != 4'h0));
    unlock(16'h0002);
    rd(OFS_CONTROL, v);
    chk("control after reset", 16'h0000, v);
    rd(OFS_DATA_BYTES_1_2, v);
    chk("data after reset", 16'h0000, v);
    chk("line after reset", 16'h0001, 16'(line));
    repeat (200) @(negedge clk_sys_in);
    rxq.delete();
  endtask
  task automatic t_byte_counts;
    int nr;
    logic [15:0] c;
    for (int code = 0; code < 6; code++)
    begin
      nr = code / 2 + 1;
      c  = 16'(code * 4 + 1);
      unlock(c);
      for (int k = 0; k < nr - 1; k++)
        wr(dreg(k), d[k]);
      if (nr > 1)
      begin
        repeat (24) @(negedge clk_sys_in);
        chk("early frames", 16'h0000, 16'(rxq.size()));
      end
      wr(dreg(nr - 1), d[nr - 1]);
      wait_ctl(c);
      chk("byte count", 16'(code + 1), 16'(rxq.size()));
      for (int k = 0; k <= code; k++)
        chk("frame byte", {7'h00, 1'b1, d[k / 2][8 * (k % 2) +: 8]},
          16'(rxq[k]));
      rxq.delete();
    end
    chk("idle line", 16'h0001, 16'(line));
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    {rstn_in, bus_wr_in, bus_rd_in, baud_tick_in, tcnt} = '0;
    bus_addr_in  = '0;
    bus_wdata_in = '0;
    d = '{16'haabb, 16'hccdd, 16'h01fe};
    repeat (20) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    t_reset_values();
    t_key_guard();
    t_disabled();
    t_soft_reset();
    t_byte_counts();
    end_sim();
  end
endmodule // tb_top
